// ### pkg/sxt_pkg.sv
// constants, opcodes and state codes of the skip/sub/xor/table execution unit
// Overview of operation
// [RULE1] taken skip inserts dummy cycle, two cycles
// [RULE2] dec-skip writes m-1, skips on zero
// [RULE3] dec-skip to acc: acc=m-1, memory kept
// [RULE4] inc-skip writes m+1, skips on zero
// [RULE5] inc-skip to acc: acc=m+1, memory kept
// [RULE6] byte set writes ones, bit set one bit
// [RULE7] skip when selected bit is one
// [RULE8] skip when selected bit is zero
// [RULE9] skip when byte is zero, nothing written
// [RULE10] copy byte to acc, skip if zero
// [RULE11] acc minus byte; carry means no borrow
// [RULE12] memory-destination subtract, same flags
// [RULE13] immediate subtract into acc, same flags
// [RULE14] swap nibbles of memory byte in place
// [RULE15] swapped byte into acc, memory kept
// [RULE16] specific page read: upper and lower pointers
// [RULE17] current page read: program page, lower pointer
// [RULE18] last page read: top page, lower pointer
// [RULE19] acc xor byte into acc, zero only
// [RULE20] acc xor byte into memory, zero only
// [RULE21] acc xor literal into acc, zero only
// [RULE22] non-skip, non-table ops take one cycle
// [RULE23] zero flag set when result all zeros
package sxt_pkg;
  localparam int DATA_W = 8;
  localparam int DADDR_W = 7;
  localparam int PADDR_W = 11;
  localparam int PWORD_W = 16;
  localparam int BIT_W = 3;
  localparam int NIB_W = 4;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] TABLE_HIGH_LATCH_RST = 8'h00;

  // opcode set handled by this unit
  typedef enum logic [4:0] {
    OP_DEC_SKIP      = 5'h00,
    OP_DEC_SKIP_ACC  = 5'h01,
    OP_INC_SKIP      = 5'h02,
    OP_INC_SKIP_ACC  = 5'h03,
    OP_SET_BYTE      = 5'h04,
    OP_SET_BIT       = 5'h05,
    OP_SKIP_BIT_SET  = 5'h06,
    OP_SKIP_BIT_CLR  = 5'h07,
    OP_SKIP_ZERO     = 5'h08,
    OP_MOVE_SKIP     = 5'h09,
    OP_SUB_ACC       = 5'h0A,
    OP_SUB_MEM       = 5'h0B,
    OP_SUB_IMM       = 5'h0C,
    OP_SWAP_MEM      = 5'h0D,
    OP_SWAP_ACC      = 5'h0E,
    OP_TAB_SPEC      = 5'h0F,
    OP_TAB_CUR       = 5'h10,
    OP_TAB_LAST      = 5'h11,
    OP_XOR_ACC       = 5'h12,
    OP_XOR_MEM       = 5'h13,
    OP_XOR_IMM       = 5'h14
  } sxt_op_t;

  // gray path idle -> exec -> dummy a -> dummy b -> idle
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_EXEC  = 2'h1,
    ST_DUM_A = 2'h3,
    ST_DUM_B = 2'h2
  } sxt_state_t;
endpackage : sxt_pkg

// ### src/sxt_dmem.sv
// data memory with registered read port
`timescale 1ns/1ps
module sxt_dmem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk_i,           // core clock
  input wire logic we_i,            // write strobe
  input wire logic [AW-1:0] waddr_i, // write address
  input wire logic [DW-1:0] wdata_i, // write data
  input wire logic [AW-1:0] raddr_i, // read address
  output logic [DW-1:0] rdata_o     // read data, one cycle later
);
  logic [DW-1:0] mem_reg [2**AW];
  logic [DW-1:0] rdata_reg;

  // read before write: same-cycle write is seen on the next read
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
    rdata_reg <= mem_reg[raddr_i];
  end

  assign rdata_o = rdata_reg;
endmodule : sxt_dmem

// ### src/sxt_alu.sv
// combinational datapath for the skip, set, subtract, swap and xor ops
`timescale 1ns/1ps
module sxt_alu (
  input sxt_pkg::sxt_op_t op_i,        // decoded operation
  input wire logic [7:0] acc_i,        // accumulator
  input wire logic [7:0] mem_i,        // memory operand
  input wire logic [7:0] lit_i,        // instruction literal
  input wire logic [2:0] bit_i,        // bit select
  output logic [7:0] res_o,            // result byte
  output logic mem_we_o,               // result goes to memory
  output logic acc_we_o,               // result goes to accumulator
  output logic skip_o,                 // skip the next instruction
  output logic z_we_o,                 // zero flag updates
  output logic arith_we_o,             // carry, aux and overflow update
  output logic c_o,                    // carry, one when no borrow
  output logic ac_o,                   // aux carry, no low-nibble borrow
  output logic ov_o,                   // signed overflow
  output logic z_o                     // result is zero
);
  import sxt_pkg::*;

  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] opnd;
  logic [7:0] mask;

  // subtractor shared by all three subtract forms
  always_comb begin
    opnd = (op_i == OP_SUB_IMM || op_i == OP_XOR_IMM) ? lit_i : mem_i;
    diff = {1'b0, acc_i} - {1'b0, opnd};
    ndiff = {1'b0, acc_i[NIB_W-1:0]} - {1'b0, opnd[NIB_W-1:0]};
    mask = BYTE_ONE << bit_i;
    c_o = ~diff[8];                                         // see [RULE11]
    ac_o = ~ndiff[4];
    ov_o = (acc_i[7] ^ opnd[7]) & (diff[7] ^ acc_i[7]);
  end

  // per-op result, destination and skip decision
  always_comb begin
    res_o = mem_i;
    mem_we_o = 1'b0;
    acc_we_o = 1'b0;
    skip_o = 1'b0;
    z_we_o = 1'b0;
    arith_we_o = 1'b0;
    unique case (op_i)
      OP_DEC_SKIP, OP_DEC_SKIP_ACC: begin
        res_o = mem_i - BYTE_ONE;
        mem_we_o = (op_i == OP_DEC_SKIP);                   // see [RULE2]
        acc_we_o = (op_i == OP_DEC_SKIP_ACC);               // see [RULE3]
        skip_o = (res_o == BYTE_ZERO);
      end
      OP_INC_SKIP, OP_INC_SKIP_ACC: begin
        res_o = mem_i + BYTE_ONE;
        mem_we_o = (op_i == OP_INC_SKIP);                   // see [RULE4]
        acc_we_o = (op_i == OP_INC_SKIP_ACC);               // see [RULE5]
        skip_o = (res_o == BYTE_ZERO);
      end
      OP_SET_BYTE: begin
        res_o = BYTE_ONES;                                  // see [RULE6]
        mem_we_o = 1'b1;
      end
      OP_SET_BIT: begin
        res_o = mem_i | mask;                               // see [RULE6]
        mem_we_o = 1'b1;
      end
      OP_SKIP_BIT_SET: skip_o = mem_i[bit_i];               // see [RULE7]
      OP_SKIP_BIT_CLR: skip_o = ~mem_i[bit_i];              // see [RULE8]
      OP_SKIP_ZERO: skip_o = (mem_i == BYTE_ZERO);          // see [RULE9]
      OP_MOVE_SKIP: begin
        acc_we_o = 1'b1;                                    // see [RULE10]
        skip_o = (mem_i == BYTE_ZERO);
      end
      OP_SUB_ACC, OP_SUB_MEM, OP_SUB_IMM: begin
        res_o = diff[7:0];
        mem_we_o = (op_i == OP_SUB_MEM);                    // see [RULE12]
        acc_we_o = (op_i != OP_SUB_MEM);                    // see [RULE11] see [RULE13]
        z_we_o = 1'b1;
        arith_we_o = 1'b1;
      end
      OP_SWAP_MEM, OP_SWAP_ACC: begin
        res_o = {mem_i[NIB_W-1:0], mem_i[7:NIB_W]};
        mem_we_o = (op_i == OP_SWAP_MEM);                   // see [RULE14]
        acc_we_o = (op_i == OP_SWAP_ACC);                   // see [RULE15]
      end
      OP_XOR_ACC, OP_XOR_MEM, OP_XOR_IMM: begin
        res_o = acc_i ^ opnd;                               // see [RULE19] see [RULE21]
        mem_we_o = (op_i == OP_XOR_MEM);                    // see [RULE20]
        acc_we_o = (op_i != OP_XOR_MEM);
        z_we_o = 1'b1;
      end
      default: begin
        res_o = mem_i;
      end
    endcase
    z_o = (res_o == BYTE_ZERO);                             // see [RULE23]
  end
endmodule : sxt_alu

// ### src/sxt_exec.sv
// execution unit for skip, set, subtract, swap, table read and xor ops
`timescale 1ns/1ps
module sxt_exec #(
  parameter int DADDR_W = sxt_pkg::DADDR_W,
  parameter int PADDR_W = sxt_pkg::PADDR_W
) (
  input wire logic clk_i,                          // core clock, 10 MHz
  input wire logic nrst_i,                         // sync reset, active low
  input wire logic op_valid_i,                     // instruction offered
  input sxt_pkg::sxt_op_t op_i,                    // instruction opcode
  input wire logic [DADDR_W-1:0] maddr_i,          // data memory address
  input wire logic [sxt_pkg::BIT_W-1:0] bit_i,     // bit select
  input wire logic [7:0] lit_i,                    // immediate literal
  input wire logic [PADDR_W-9:0] table_pointer_upper_i, // table page
  input wire logic [7:0] table_pointer_lower_i,    // table offset
  input wire logic [PADDR_W-9:0] pc_page_i,        // current program page
  input wire logic [sxt_pkg::PWORD_W-1:0] prog_data_i, // program word
  input wire logic acc_load_i,                     // load accumulator
  input wire logic [7:0] acc_data_i,               // accumulator value
  input wire logic mem_load_i,                     // load data memory
  input wire logic [DADDR_W-1:0] mem_load_addr_i,  // load address
  input wire logic [7:0] mem_load_data_i,          // load data
  output logic ready_o,                            // can take an op
  output logic done_o,                             // op finished, pulse
  output logic skip_o,                             // last op skipped
  output logic [7:0] acc_o,                        // accumulator
  output logic carry_o,                            // carry flag
  output logic aux_carry_flag_o,                   // aux carry flag
  output logic overflow_flag_o,                    // overflow flag
  output logic zero_o,                             // zero flag
  output logic [7:0] table_high_latch_o,           // table high byte
  output logic [PADDR_W-1:0] prog_addr_o,          // table read address
  output logic prog_rd_o,                          // table read strobe
  output logic mem_we_o,                           // memory write seen
  output logic [DADDR_W-1:0] mem_waddr_o,          // memory write address
  output logic [7:0] mem_wdata_o                   // memory write data
);
  import sxt_pkg::*;

  localparam int PG_W = PADDR_W - 8;

  typedef struct packed {
    sxt_state_t st;
    sxt_op_t op;
    logic [DADDR_W-1:0] addr;
    logic [BIT_W-1:0] bsel;
    logic [7:0] lit;
    logic [7:0] acc;
    logic c;
    logic ac;
    logic ov;
    logic z;
    logic [7:0] table_high_latch;
    logic ready;
    logic done;
    logic skip;
    logic [PADDR_W-1:0] paddr;
    logic prd;
    logic mwe;
    logic [DADDR_W-1:0] mwa;
    logic [7:0] mwd;
  } sxt_regs_t;

  sxt_regs_t r_reg;
  sxt_regs_t r_next;

  logic dm_we;
  logic [DADDR_W-1:0] dm_waddr;
  logic [7:0] dm_wdata;
  logic [7:0] dm_rdata;
  logic [7:0] alu_res;
  logic alu_mem_we;
  logic alu_acc_we;
  logic alu_skip;
  logic alu_z_we;
  logic alu_arith_we;
  logic alu_c;
  logic alu_ac;
  logic alu_ov;
  logic alu_z;
  logic tab_in;
  logic tab_q;
  logic [PADDR_W-1:0] tab_addr;

  // data memory: read is issued in idle, data arrives in exec
  sxt_dmem #(
    .AW(DADDR_W),
    .DW(DATA_W)
  ) u_dmem (
    .clk_i(clk_i),
    .we_i(dm_we),
    .waddr_i(dm_waddr),
    .wdata_i(dm_wdata),
    .raddr_i(maddr_i),
    .rdata_o(dm_rdata)
  );

  // datapath works on the captured op and the memory byte
  sxt_alu u_alu (
    .op_i(r_reg.op),
    .acc_i(r_reg.acc),
    .mem_i(dm_rdata),
    .lit_i(r_reg.lit),
    .bit_i(r_reg.bsel),
    .res_o(alu_res),
    .mem_we_o(alu_mem_we),
    .acc_we_o(alu_acc_we),
    .skip_o(alu_skip),
    .z_we_o(alu_z_we),
    .arith_we_o(alu_arith_we),
    .c_o(alu_c),
    .ac_o(alu_ac),
    .ov_o(alu_ov),
    .z_o(alu_z)
  );

  // table op detection and program address forming
  always_comb begin
    tab_in = (op_i == OP_TAB_SPEC) || (op_i == OP_TAB_CUR) || (op_i == OP_TAB_LAST);
    tab_q = (r_reg.op == OP_TAB_SPEC) || (r_reg.op == OP_TAB_CUR)
      || (r_reg.op == OP_TAB_LAST);
    unique case (op_i)
      OP_TAB_SPEC: tab_addr = {table_pointer_upper_i, table_pointer_lower_i}; // see [RULE16]
      OP_TAB_CUR: tab_addr = {pc_page_i, table_pointer_lower_i};             // see [RULE17]
      default: tab_addr = {{PG_W{1'b1}}, table_pointer_lower_i};             // see [RULE18]
    endcase
  end

  // sequencer: idle takes an op, exec does the work (dummy a for table reads), dummy pair only
  // for a taken skip or a table read, so those cost two slots
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.prd = 1'b0;
    dm_we = 1'b0;
    dm_waddr = r_reg.addr;
    dm_wdata = alu_res;
    unique case (r_reg.st)
      ST_IDLE: begin
        if (op_valid_i && r_reg.ready) begin
          r_next.st = ST_EXEC;
          r_next.ready = 1'b0;
          r_next.skip = 1'b0;
          r_next.op = op_i;
          r_next.addr = maddr_i;
          r_next.bsel = bit_i;
          r_next.lit = lit_i;
          if (tab_in) begin
            r_next.prd = 1'b1;
            r_next.paddr = tab_addr;
          end
        end else if (mem_load_i) begin
          // loads only when no op is taken, so they never race a write-back
          dm_we = 1'b1;
          dm_waddr = mem_load_addr_i;
          dm_wdata = mem_load_data_i;
        end else if (acc_load_i) begin
          r_next.acc = acc_data_i;
        end
      end
      ST_EXEC: begin
        if (tab_q) begin
          r_next.st = ST_DUM_A;
        end else begin
          dm_we = alu_mem_we;                               // see [RULE2] see [RULE4]
          if (alu_acc_we) begin
            r_next.acc = alu_res;                           // see [RULE3] see [RULE5]
          end
          if (alu_z_we) begin
            r_next.z = alu_z;                               // see [RULE23]
          end
          if (alu_arith_we) begin
            r_next.c = alu_c;                               // see [RULE11] see [RULE12]
            r_next.ac = alu_ac;
            r_next.ov = alu_ov;
          end
          r_next.skip = alu_skip;
          if (alu_skip) begin
            r_next.st = ST_DUM_A;                           // see [RULE1]
          end else begin
            r_next.st = ST_IDLE;                            // see [RULE22]
            r_next.done = 1'b1;
            r_next.ready = 1'b1;
          end
        end
      end
      ST_DUM_A: begin
        // program word answers one cycle after the read strobe
        if (tab_q) begin
          dm_we = 1'b1;                                     // see [RULE16]
          dm_wdata = prog_data_i[7:0];
          r_next.table_high_latch = prog_data_i[PWORD_W-1:8];
        end
        r_next.st = ST_DUM_B;
      end
      ST_DUM_B: begin
        r_next.st = ST_IDLE;
        r_next.done = 1'b1;
        r_next.ready = 1'b1;
      end
    endcase
    r_next.mwe = dm_we;
    r_next.mwa = dm_waddr;
    r_next.mwd = dm_wdata;
  end

  // single state register; ready comes up in the first reset cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      r_reg <= '0;
      r_reg.ready <= 1'b1;
      r_reg.acc <= ACC_RST;
      r_reg.table_high_latch <= TABLE_HIGH_LATCH_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign ready_o = r_reg.ready;
  assign done_o = r_reg.done;
  assign skip_o = r_reg.skip;
  assign acc_o = r_reg.acc;
  assign carry_o = r_reg.c;
  assign aux_carry_flag_o = r_reg.ac;
  assign overflow_flag_o = r_reg.ov;
  assign zero_o = r_reg.z;
  assign table_high_latch_o = r_reg.table_high_latch;
  assign prog_addr_o = r_reg.paddr;
  assign prog_rd_o = r_reg.prd;
  assign mem_we_o = r_reg.mwe;
  assign mem_waddr_o = r_reg.mwa;
  assign mem_wdata_o = r_reg.mwd;

  // helpers for the checks below
  logic exec_c;
  logic flagless;
  logic [7:0] swp;
  logic bitv;
  logic [7:0] prog_hi;
  always_comb begin
    exec_c = (r_reg.st == ST_EXEC);
    flagless = !(r_reg.op inside {OP_SUB_ACC, OP_SUB_MEM, OP_SUB_IMM,
      OP_XOR_ACC, OP_XOR_MEM, OP_XOR_IMM});
    swp = {dm_rdata[NIB_W-1:0], dm_rdata[7:NIB_W]};
    bitv = dm_rdata[r_reg.bsel];
    prog_hi = prog_data_i[PWORD_W-1:8];
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_take;
    r_reg.ready && op_valid_i;
  endsequence

  sequence s_exec_plain;
    exec_c && !tab_q && !alu_skip;
  endsequence

  sequence s_dummy_pair;
    !ready_o ##1 (!ready_o && !done_o);
  endsequence

  a_skip_two_slots: assert property ( // see [RULE1]
    (exec_c && !tab_q && alu_skip) |=> s_dummy_pair ##1 (done_o && skip_o && ready_o))
    else $error("taken skip did not cost two slots");

  a_plain_one_slot: assert property ( // see [RULE22]
    s_take ##1 s_exec_plain |=> (done_o && ready_o && !skip_o))
    else $error("plain op did not finish in one slot");

  a_flags_held: assert property ( // see [RULE2]
    (exec_c && flagless) |=> $stable({carry_o, aux_carry_flag_o, overflow_flag_o, zero_o}))
    else $error("flag changed on a flagless op");

  a_dec_write: assert property ( // see [RULE2]
    (exec_c && r_reg.op == OP_DEC_SKIP) |=> (mem_we_o && mem_wdata_o == $past(dm_rdata) - 8'h01))
    else $error("decrement did not write m minus one");

  a_sub_carry: assert property ( // see [RULE11]
    (exec_c && r_reg.op == OP_SUB_ACC) |=> (carry_o == ($past(r_reg.acc) >= $past(dm_rdata))))
    else $error("subtract carry wrong");

  a_xor_zero: assert property ( // see [RULE19]
    (exec_c && r_reg.op == OP_XOR_ACC) |=> (zero_o == (acc_o == 8'h00)) && $stable(carry_o))
    else $error("xor zero flag wrong");

  a_swap_acc: assert property ( // see [RULE15]
    (exec_c && r_reg.op == OP_SWAP_ACC) |=> (acc_o == $past(swp) && !mem_we_o))
    else $error("nibble swap to acc wrong");

  a_bit_clr_skip: assert property ( // see [RULE8]
    (exec_c && r_reg.op == OP_SKIP_BIT_CLR) |=> ##2 (skip_o == !$past(bitv, 3)))
    else $error("bit clear skip wrong");

  a_tab_high: assert property ( // see [RULE16]
    (r_reg.st == ST_DUM_A && tab_q) |=> (table_high_latch_o == $past(prog_hi) && mem_we_o))
    else $error("table high latch wrong");

  a_last_page: assert property ( // see [RULE18]
    (prog_rd_o && r_reg.op == OP_TAB_LAST) |-> (prog_addr_o[PADDR_W-1:8] == {PG_W{1'b1}}))
    else $error("last page address wrong");

endmodule : sxt_exec

// ### tb/mcu_skip_sub_xor_table_exec_test.sv
// self-checking bench for the skip/sub/xor/table execution unit
`timescale 1ns/1ps
module mcu_skip_sub_xor_table_exec_test;
  import sxt_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic op_valid_i = 1'b0;
  sxt_op_t op_i = OP_DEC_SKIP;
  logic [6:0] maddr_i = 7'h00;
  logic [2:0] bit_i = 3'h0;
  logic [7:0] lit_i = 8'h00;
  logic [2:0] tpu_i = 3'h0;
  logic [7:0] tpl_i = 8'h00;
  logic [2:0] pc_page_i = 3'h0;
  logic [15:0] prog_data_i = 16'h0000;
  logic acc_load_i = 1'b0;
  logic [7:0] acc_data_i = 8'h00;
  logic mem_load_i = 1'b0;
  logic [6:0] mem_load_addr_i = 7'h00;
  logic [7:0] mem_load_data_i = 8'h00;
  logic ready_o, done_o, skip_o, carry_o, aux_carry_flag_o, overflow_flag_o, zero_o;
  logic prog_rd_o, mem_we_o;
  logic [7:0] acc_o, table_high_latch_o, mem_wdata_o;
  logic [10:0] prog_addr_o;
  logic [6:0] mem_waddr_o;
  // shadow state of the expected machine
  logic [7:0] smem [128];
  logic [7:0] e_acc, e_th, e_wd;
  logic e_c, e_ac, e_ov, e_z, e_skip, e_we;
  logic [10:0] e_pa;
  logic [15:0] word;
  int e_cyc;
  int miscompares = 0;
  int total_checks = 0;
  integer seed = 32'h78dd;

  sxt_exec dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .maddr_i(maddr_i), .bit_i(bit_i), .lit_i(lit_i),
    .table_pointer_upper_i(tpu_i), .table_pointer_lower_i(tpl_i),
    .pc_page_i(pc_page_i), .prog_data_i(prog_data_i),
    .acc_load_i(acc_load_i), .acc_data_i(acc_data_i), .mem_load_i(mem_load_i),
    .mem_load_addr_i(mem_load_addr_i), .mem_load_data_i(mem_load_data_i),
    .ready_o(ready_o), .done_o(done_o), .skip_o(skip_o), .acc_o(acc_o),
    .carry_o(carry_o), .aux_carry_flag_o(aux_carry_flag_o),
    .overflow_flag_o(overflow_flag_o), .zero_o(zero_o),
    .table_high_latch_o(table_high_latch_o), .prog_addr_o(prog_addr_o),
    .prog_rd_o(prog_rd_o), .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o),
    .mem_wdata_o(mem_wdata_o)
  );

  // 100 ns period
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // reset for five cycles; memory keeps its contents, so the shadow does too
  task automatic do_reset;
    nrst_i = 1'b0;
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    {e_acc, e_th, e_c, e_ac, e_ov, e_z} = '0;
    chk({ready_o, done_o, skip_o, prog_rd_o, mem_we_o}, 16'h0010);
    chk({acc_o, table_high_latch_o}, 16'h0000);
    chk({carry_o, aux_carry_flag_o, overflow_flag_o, zero_o}, 16'h0000);
  endtask : do_reset

  task automatic load_mem(input logic [6:0] a, input logic [7:0] d);
    mem_load_i = 1'b1;
    mem_load_addr_i = a;
    mem_load_data_i = d;
    @(negedge clk_i);
    mem_load_i = 1'b0;
    smem[a] = d;
    @(negedge clk_i);
  endtask : load_mem

  task automatic load_acc(input logic [7:0] d);
    acc_load_i = 1'b1;
    acc_data_i = d;
    @(negedge clk_i);
    acc_load_i = 1'b0;
    e_acc = d;
    @(negedge clk_i);
  endtask : load_acc

  // expected effect of one op on the shadow state
  task automatic model(input sxt_op_t op, input logic [6:0] a, input logic [2:0] b,
                       input logic [7:0] l);
    logic [7:0] m, o, r;
    logic tab;
    m = smem[a];
    o = (op inside {OP_SUB_IMM, OP_XOR_IMM}) ? l : m;
    r = 8'h00;
    e_skip = 1'b0;
    tab = 1'b0;
    case (op)
      OP_DEC_SKIP, OP_DEC_SKIP_ACC: begin r = m - 8'h01; e_skip = (r == 8'h00); end
      OP_INC_SKIP, OP_INC_SKIP_ACC: begin r = m + 8'h01; e_skip = (r == 8'h00); end
      OP_SET_BYTE: r = 8'hFF;
      OP_SET_BIT: r = m | (8'h01 << b);
      OP_SKIP_BIT_SET: e_skip = m[b];
      OP_SKIP_BIT_CLR: e_skip = ~m[b];
      OP_SKIP_ZERO: e_skip = (m == 8'h00);
      OP_MOVE_SKIP: begin r = m; e_skip = (m == 8'h00); end
      OP_SUB_ACC, OP_SUB_MEM, OP_SUB_IMM: begin
        r = e_acc - o;
        e_c = (e_acc >= o);
        e_ac = (e_acc[3:0] >= o[3:0]);
        e_ov = (e_acc[7] ^ o[7]) & (r[7] ^ e_acc[7]);
        e_z = (r == 8'h00);
      end
      OP_SWAP_MEM, OP_SWAP_ACC: r = {m[3:0], m[7:4]};
      OP_XOR_ACC, OP_XOR_MEM, OP_XOR_IMM: begin r = e_acc ^ o; e_z = (r == 8'h00); end
      default: begin
        tab = 1'b1;
        r = word[7:0];
        e_th = word[15:8];
        e_pa = (op == OP_TAB_SPEC) ? {tpu_i, tpl_i} :
               (op == OP_TAB_CUR) ? {pc_page_i, tpl_i} : {3'h7, tpl_i};
      end
    endcase
    e_we = (op inside {OP_DEC_SKIP, OP_INC_SKIP, OP_SET_BYTE, OP_SET_BIT, OP_SUB_MEM,
                       OP_SWAP_MEM, OP_TAB_SPEC, OP_TAB_CUR, OP_TAB_LAST, OP_XOR_MEM});
    if (e_we) smem[a] = r;
    e_wd = r;
    if (op inside {OP_DEC_SKIP_ACC, OP_INC_SKIP_ACC, OP_MOVE_SKIP, OP_SUB_ACC, OP_SUB_IMM,
                   OP_SWAP_ACC, OP_XOR_ACC, OP_XOR_IMM}) e_acc = r;
    e_cyc = (e_skip || tab) ? 4 : 2;
  endtask : model

  // offer one op at a falling edge and follow it to done_o
  task automatic run_op(input sxt_op_t op, input logic [6:0] a, input logic [2:0] b,
                        input logic [7:0] l);
    int cyc, nw, hold;
    logic [6:0] wa;
    logic [7:0] wd;
    cyc = 0;
    nw = 0;
    hold = 0;
    wa = 7'h00;
    wd = 8'h00;
    word = $random(seed);
    model(op, a, b, l);
    chk(ready_o, 1'b1);
    op_valid_i = 1'b1;
    op_i = op;
    maddr_i = a;
    bit_i = b;
    lit_i = l;
    do begin
      @(negedge clk_i);
      cyc++;
      if (cyc == 1) op_valid_i = 1'b0;
      if (mem_we_o === 1'b1) begin nw++; wa = mem_waddr_o; wd = mem_wdata_o; end
      // program word held two cycles past the strobe, scrambled otherwise
      if (prog_rd_o === 1'b1) begin
        chk(prog_addr_o, e_pa);
        prog_data_i = word;
        hold = 2;
      end else if (hold > 0) hold--;
      else prog_data_i = ~prog_data_i;
      if (done_o !== 1'b1) chk(ready_o, 1'b0);
    end while (done_o !== 1'b1 && cyc < 20);
    if (cyc >= 20) begin
      miscompares++;
      final_report();
    end
    chk(cyc, e_cyc);
    chk(skip_o, e_skip);
    chk(acc_o, e_acc);
    chk({carry_o, aux_carry_flag_o, overflow_flag_o}, {e_c, e_ac, e_ov});
    chk(zero_o, e_z);
    chk(table_high_latch_o, e_th);
    chk(nw, e_we);
    if (e_we) chk({1'b0, wa, wd}, {1'b0, a, e_wd});
  endtask : run_op

  initial begin
    int k;
    logic [7:0] cv;
    @(negedge clk_i);
    do_reset();
    for (k = 0; k < 128; k++) load_mem(k[6:0], $random(seed));
    // corners: skips taken, low-nibble borrow, overflow and every opcode once
    for (k = 0; k < 21; k++) begin
      cv = (k <= 1) ? 8'h01 : (k <= 3) ? 8'hFF : (k == 6) ? 8'h80 : (k == 7) ? 8'h7F : 8'h00;
      load_acc(8'h80);
      load_mem(7'h05, cv);
      tpu_i = 3'h5;
      tpl_i = 8'hA3;
      pc_page_i = 3'h2;
      run_op(sxt_op_t'(k), 7'h05, 3'h7, 8'h01);
    end
    // equal operands: zero result, no borrow; then xor into memory and an immediate subtract that borrows
    load_acc(8'h3C);
    load_mem(7'h09, 8'h3C);
    run_op(OP_SUB_ACC, 7'h09, 3'h0, 8'h00);
    run_op(OP_XOR_MEM, 7'h09, 3'h0, 8'h00);
    run_op(OP_SUB_IMM, 7'h09, 3'h0, 8'h01);
    // random ops back to back
    for (k = 0; k < 300; k++) begin
      if ($random(seed) % 4 == 0) load_acc($random(seed));
      tpu_i = $random(seed);
      tpl_i = $random(seed);
      pc_page_i = $random(seed);
      run_op(sxt_op_t'({$random(seed)} % 21), $random(seed), $random(seed), $random(seed));
    end
    // second reset in mid-run, then work on
    do_reset();
    run_op(OP_MOVE_SKIP, 7'h05, 3'h0, 8'h00);
    final_report();
  end
endmodule : mcu_skip_sub_xor_table_exec_test
